//--- pkg/range_decode_defines.svh
`ifndef RANGE_DECODE_DEFINES_SVH
`define RANGE_DECODE_DEFINES_SVH
// How it works
// - general range mask is five bits: A[5:1] for I/O, A[19:15] for memory.
// - a set general range mask bit drops that base bit from the compare.
// - chip select 0 mask bits drop base bits 3:0 from the compare.
// - chip select 1 mask is four bits: A[4:1] I/O, A[18:15] memory.
// - write-decode enable 0 ignores writes to the range, 1 decodes them.
// - resume status is read only: 0 not resuming, 1 ready to resume.

`define OFS_GNR_BASE    8'h48
`define OFS_GNR_CTRL    8'h49
`define OFS_SEL0_BASE   8'h4A
`define OFS_SEL0_CTRL   8'h4B
`define OFS_SEL1_BASE   8'h4C
`define OFS_SEL1_CTRL   8'h4D
`define OFS_IDLE_EN     8'h4E
`define OFS_IDLE_CNT    8'h4F
`define OFS_PWR_CTRL5   8'h50
`define OFS_IRQ_STATUS  8'h60
`define OFS_IRQ_MASK    8'h64
`define REG_RESET       8'h00
`define CTRL_A9_BIT     7
`define CTRL_WR_BIT     6
`define CTRL_RD_BIT     5
`define CTRL_EARLY_BIT  4
`define P5_SMI_BIT      7
`define P5_DOZE_BIT     3
`define P5_RESUME_BIT   2
`define P5_SUSP_BIT     1
`define P5_START_BIT    0
`define P5_RW_MASK      8'hB0
`endif

//--- pkg/range_decode_pkg.sv
package range_decode_pkg;
    typedef struct packed {
        logic        valid;
        logic        is_mem;
        logic        is_write;
        logic [23:1] addr;
    } host_cycle_t;

    typedef struct packed {
        logic sel0_n;
        logic sel1_n;
        logic gnr_hit;
    } decode_out_t;
endpackage

//--- verilog/range_match.sv
`timescale 1ns/1ns
module range_match (
    input  wire logic        is_mem_i,
    input  wire logic [23:1] addr_i,
    input  wire logic [8:0]  base_i,
    input  wire logic [4:0]  mask_i,
    output logic             hit_o
);
    logic [8:0] cmp;
    logic [8:0] care;
    // memory ranges compare A[23:15], I/O ranges A[9:1]
    assign cmp  = is_mem_i ? addr_i[23:15] : addr_i[9:1];
    assign care = ~{4'h0, mask_i};
    assign hit_o = ((cmp ^ base_i) & care) == 9'h000;
endmodule

//--- verilog/range_decode.sv
`timescale 1ns/1ns
`include "range_decode_defines.svh"
module range_decode (
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic [7:0]                   s_axi_awaddr_i,
    input  wire logic                         s_axi_awvalid_i,
    output logic                              s_axi_awready_o,
    input  wire logic [31:0]                  s_axi_wdata_i,
    input  wire logic [3:0]                   s_axi_wstrb_i,
    input  wire logic                         s_axi_wvalid_i,
    output logic                              s_axi_wready_o,
    output logic [1:0]                        s_axi_bresp_o,
    output logic                              s_axi_bvalid_o,
    input  wire logic                         s_axi_bready_i,
    input  wire logic [7:0]                   s_axi_araddr_i,
    input  wire logic                         s_axi_arvalid_i,
    output logic                              s_axi_arready_o,
    output logic [31:0]                       s_axi_rdata_o,
    output logic [1:0]                        s_axi_rresp_o,
    output logic                              s_axi_rvalid_o,
    input  wire logic                         s_axi_rready_i,
    input  wire range_decode_pkg::host_cycle_t host_cycle_i,
    input  wire logic                         resume_ready_i,
    input  wire logic                         doze_timeout_i,
    input  wire logic                         suspend_active_i,
    output range_decode_pkg::decode_out_t     decode_o,
    output logic                              general_range_activity_o,
    output logic                              idle_reload_o,
    output logic                              smi_request_o,
    output logic                              doze_start_o,
    output logic                              suspend_start_o,
    output logic                              irq_o
);
    import range_decode_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  gnr_base_ff;
    logic [7:0]  gnr_ctrl_ff;
    logic [7:0]  sel0_base_ff;
    logic [7:0]  sel0_ctrl_ff;
    logic [7:0]  sel1_base_ff;
    logic [7:0]  sel1_ctrl_ff;
    logic [7:0]  idle_en_ff;
    logic [7:0]  idle_cnt_ff;
    logic [7:0]  pwr5_ff;
    logic [7:0]  irq_status_ff;
    logic [7:0]  irq_mask_ff;
    logic [7:0]  awaddr_ff;
    logic [7:0]  wdata_ff;
    logic        aw_have_ff;
    logic        w_have_ff;
    logic        w_lane_ff;
    logic        resume_s1_ff;
    logic        resume_ff;
    logic        doze_s1_ff;
    logic        doze_ff;
    logic        susp_s1_ff;
    logic        susp_ff;
    logic        wr_go;
    logic        gnr_hit;
    logic        sel0_hit;
    logic        sel1_hit;
    logic        gnr_act;
    logic        sel0_act;
    logic        sel1_act;
    logic [2:0]  events;
    decode_out_t nxt_decode;

    // printed offsets 48h-50h are consecutive register indices, so byte address = index * 4, low 8 bits kept (20h-40h); 60h and 64h are used as is
    function automatic logic [7:0] byte_addr(input logic [7:0] ofs);
        byte_addr = (ofs == `OFS_IRQ_STATUS || ofs == `OFS_IRQ_MASK) ? ofs : {ofs[5:0], 2'h0};
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK)
                     || (a >= byte_addr(`OFS_GNR_BASE) && a <= byte_addr(`OFS_PWR_CTRL5));
    endfunction

    // a cycle is decoded only when its direction is enabled
    function automatic logic dir_ok(input logic [7:0] ctrl, input logic wr);
        dir_ok = wr ? ctrl[`CTRL_WR_BIT] : ctrl[`CTRL_RD_BIT];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data accepted in either order
    assign s_axi_awready_o = !aw_have_ff && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_have_ff && !s_axi_bvalid_o;
    assign wr_go           = aw_have_ff && w_have_ff;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_have_ff     <= 1'b0;
            w_have_ff      <= 1'b0;
            awaddr_ff      <= 8'h00;
            wdata_ff       <= 8'h00;
            w_lane_ff      <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= 2'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_ff <= 1'b1;
                awaddr_ff  <= {s_axi_awaddr_i[7:2], 2'h0};
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata_i[7:0];
                w_lane_ff <= s_axi_wstrb_i[0];
            end
            if (wr_go) begin
                aw_have_ff     <= 1'b0;
                w_have_ff      <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= known_addr(awaddr_ff) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // lane 0 carries the register byte; without it a write is answered but changes nothing
    logic       wr_strobe_ok;
    assign wr_strobe_ok = w_lane_ff;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gnr_base_ff  <= `REG_RESET;
            gnr_ctrl_ff  <= `REG_RESET;
            sel0_base_ff <= `REG_RESET;
            sel0_ctrl_ff <= `REG_RESET;
            sel1_base_ff <= `REG_RESET;
            sel1_ctrl_ff <= `REG_RESET;
            idle_en_ff   <= `REG_RESET;
            idle_cnt_ff  <= `REG_RESET;
            irq_mask_ff  <= `REG_RESET;
        end else if (wr_go && wr_strobe_ok) begin
            if (awaddr_ff == byte_addr(`OFS_GNR_BASE))  gnr_base_ff  <= wdata_ff;
            if (awaddr_ff == byte_addr(`OFS_GNR_CTRL))  gnr_ctrl_ff  <= wdata_ff;
            if (awaddr_ff == byte_addr(`OFS_SEL0_BASE)) sel0_base_ff <= wdata_ff;
            if (awaddr_ff == byte_addr(`OFS_SEL0_CTRL)) sel0_ctrl_ff <= wdata_ff;
            if (awaddr_ff == byte_addr(`OFS_SEL1_BASE)) sel1_base_ff <= wdata_ff;
            if (awaddr_ff == byte_addr(`OFS_SEL1_CTRL)) sel1_ctrl_ff <= wdata_ff;
            // reserved bit 4 is held at zero
            if (awaddr_ff == byte_addr(`OFS_IDLE_EN))   idle_en_ff   <= wdata_ff & 8'hEF;
            if (awaddr_ff == byte_addr(`OFS_IDLE_CNT))  idle_cnt_ff  <= wdata_ff;
            if (awaddr_ff == byte_addr(`OFS_IRQ_MASK))  irq_mask_ff  <= wdata_ff & 8'h07;
        end
    end

    // control five: only smi, irq8 polarity and clock bit are stored; doze and start are strobes, the rest read only
    logic wr_pwr5;
    assign wr_pwr5 = wr_go && wr_strobe_ok && awaddr_ff == byte_addr(`OFS_PWR_CTRL5);
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr5_ff         <= `REG_RESET;
            doze_start_o    <= 1'b0;
            suspend_start_o <= 1'b0;
        end else begin
            doze_start_o    <= wr_pwr5 && wdata_ff[`P5_DOZE_BIT];
            suspend_start_o <= wr_pwr5 && wdata_ff[`P5_START_BIT];
            if (wr_pwr5) pwr5_ff <= wdata_ff & `P5_RW_MASK & 8'hDF | wdata_ff & 8'h20;
        end
    end
    assign smi_request_o = pwr5_ff[`P5_SMI_BIT];

    // status lines from the timer logic arrive asynchronously
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            resume_s1_ff <= 1'b0;
            resume_ff    <= 1'b0;
            doze_s1_ff   <= 1'b0;
            doze_ff      <= 1'b0;
            susp_s1_ff   <= 1'b0;
            susp_ff      <= 1'b0;
        end else begin
            resume_s1_ff <= resume_ready_i;
            resume_ff    <= resume_s1_ff;
            doze_s1_ff   <= doze_timeout_i;
            doze_ff      <= doze_s1_ff;
            susp_s1_ff   <= suspend_active_i;
            susp_ff      <= susp_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoders: 9-bit base is control[7] over the base byte
    range_match u_gnr (
        .is_mem_i (host_cycle_i.is_mem),
        .addr_i   (host_cycle_i.addr),
        .base_i   ({gnr_ctrl_ff[`CTRL_A9_BIT], gnr_base_ff}),
        .mask_i   (gnr_ctrl_ff[4:0]),
        .hit_o    (gnr_hit)
    );
    range_match u_sel0 (
        .is_mem_i (host_cycle_i.is_mem),
        .addr_i   (host_cycle_i.addr),
        .base_i   ({sel0_ctrl_ff[`CTRL_A9_BIT], sel0_base_ff}),
        .mask_i   ({1'b0, sel0_ctrl_ff[3:0]}),
        .hit_o    (sel0_hit)
    );
    range_match u_sel1 (
        .is_mem_i (host_cycle_i.is_mem),
        .addr_i   (host_cycle_i.addr),
        .base_i   ({sel1_ctrl_ff[`CTRL_A9_BIT], sel1_base_ff}),
        .mask_i   ({1'b0, sel1_ctrl_ff[3:0]}),
        .hit_o    (sel1_hit)
    );

    assign gnr_act  = host_cycle_i.valid && gnr_hit
                      && dir_ok(gnr_ctrl_ff, host_cycle_i.is_write);
    assign sel0_act = host_cycle_i.valid && sel0_hit
                      && dir_ok(sel0_ctrl_ff, host_cycle_i.is_write);
    assign sel1_act = host_cycle_i.valid && sel1_hit
                      && dir_ok(sel1_ctrl_ff, host_cycle_i.is_write);

    always_comb begin
        nxt_decode.sel0_n  = !sel0_act;
        nxt_decode.sel1_n  = !sel1_act;
        nxt_decode.gnr_hit = gnr_act;
    end

    // registered outputs: selects trail the cycle by one clock
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            decode_o                 <= '{sel0_n: 1'b1, sel1_n: 1'b1, gnr_hit: 1'b0};
            general_range_activity_o <= 1'b0;
            idle_reload_o            <= 1'b0;
        end else begin
            decode_o                 <= nxt_decode;
            general_range_activity_o <= gnr_act;
            idle_reload_o            <= (gnr_act && idle_en_ff[3]) || (sel0_act && idle_en_ff[6])
                                        || (sel1_act && idle_en_ff[7]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky events: bit0 general range, bit1 select 0, bit2 select 1; set beats clear
    assign events = {sel1_act, sel0_act, gnr_act};
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status_ff <= `REG_RESET;
        end else begin
            if (wr_go && wr_strobe_ok && awaddr_ff == `OFS_IRQ_STATUS)
                irq_status_ff <= (irq_status_ff & ~wdata_ff) | {5'h00, events};
            else
                irq_status_ff <= irq_status_ff | {5'h00, events};
        end
    end
    assign irq_o = |(irq_status_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rd_val;
    logic [7:0] pwr5_view;
    logic [7:0] araddr_w;
    assign araddr_w  = {s_axi_araddr_i[7:2], 2'h0};
    assign pwr5_view = {pwr5_ff[7:4], doze_ff, resume_ff, susp_ff, 1'b0};
    always_comb begin
        rd_val = 8'h00;
        if (araddr_w == byte_addr(`OFS_GNR_BASE))   rd_val = gnr_base_ff;
        if (araddr_w == byte_addr(`OFS_GNR_CTRL))   rd_val = gnr_ctrl_ff;
        if (araddr_w == byte_addr(`OFS_SEL0_BASE))  rd_val = sel0_base_ff;
        if (araddr_w == byte_addr(`OFS_SEL0_CTRL))  rd_val = sel0_ctrl_ff;
        if (araddr_w == byte_addr(`OFS_SEL1_BASE))  rd_val = sel1_base_ff;
        if (araddr_w == byte_addr(`OFS_SEL1_CTRL))  rd_val = sel1_ctrl_ff;
        if (araddr_w == byte_addr(`OFS_IDLE_EN))    rd_val = idle_en_ff;
        if (araddr_w == byte_addr(`OFS_IDLE_CNT))   rd_val = idle_cnt_ff;
        if (araddr_w == byte_addr(`OFS_PWR_CTRL5))  rd_val = pwr5_view;
        if (araddr_w == `OFS_IRQ_STATUS)            rd_val = irq_status_ff;
        if (araddr_w == `OFS_IRQ_MASK)              rd_val = irq_mask_ff;
    end

    function automatic logic rd_known(input logic [7:0] a);
        rd_known = (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK)
                   || (a >= 8'h20 && a <= 8'h40);
    endfunction

    assign s_axi_arready_o = !s_axi_rvalid_o;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= 2'h0;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= {24'h000000, rd_val};
            s_axi_rresp_o  <= rd_known(araddr_w) ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_wr_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        host_cycle_i.valid && host_cycle_i.is_write && !gnr_ctrl_ff[`CTRL_WR_BIT]
        |=> !general_range_activity_o) else $error("write decoded while disabled");
    a_rd_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        host_cycle_i.valid && !host_cycle_i.is_write && !sel0_ctrl_ff[`CTRL_RD_BIT]
        |=> decode_o.sel0_n) else $error("read decoded while disabled");
    a_gnr_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        host_cycle_i.valid && !host_cycle_i.is_mem && gnr_ctrl_ff[`CTRL_RD_BIT]
        && !host_cycle_i.is_write && gnr_ctrl_ff[4:0] == 5'h1F
        && host_cycle_i.addr[9:6] == {gnr_ctrl_ff[7], gnr_base_ff[7:5]}
        |=> general_range_activity_o) else $error("masked io compare missed");
    // stable guards keep a register write landing mid-check from faking a miss
    a_gnr_exact: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        general_range_activity_o && gnr_ctrl_ff[4:0] == 5'h00 && $stable(gnr_base_ff)
        && $stable(gnr_ctrl_ff) && !$past(host_cycle_i.is_mem)
        |-> $past(host_cycle_i.addr[9:1]) == {gnr_ctrl_ff[7], gnr_base_ff})
        else $error("unmasked compare wrong");
    a_sel0_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !decode_o.sel0_n && $stable(sel0_ctrl_ff) && $stable(sel0_base_ff)
        |-> ($past(host_cycle_i.is_mem) ? $past(host_cycle_i.addr[23:19])
             : $past(host_cycle_i.addr[9:5])) == {sel0_ctrl_ff[7], sel0_base_ff[7:4]})
        else $error("select 0 compare wrong");
    a_sel1_mem: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !decode_o.sel1_n && $stable(sel1_ctrl_ff) && $stable(sel1_base_ff)
        && $past(host_cycle_i.is_mem)
        |-> $past(host_cycle_i.addr[23:19]) == {sel1_ctrl_ff[7], sel1_base_ff[7:4]})
        else $error("select 1 upper bits wrong");
    a_resume_rd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        resume_ready_i [*3] |-> pwr5_view[`P5_RESUME_BIT])
        else $error("resume status not shown");
    a_irq_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        gnr_act |=> irq_status_ff[0]) else $error("event not latched");

    a_sel1_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        host_cycle_i.valid && host_cycle_i.is_write && !sel1_ctrl_ff[`CTRL_WR_BIT]
        |=> decode_o.sel1_n) else $error("select 1 write decoded while disabled");
    a_resume_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !resume_ready_i [*3] |-> !pwr5_view[`P5_RESUME_BIT])
        else $error("resume status stuck high");
    a_idle_sel1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sel1_act && idle_en_ff[7] |=> idle_reload_o) else $error("idle reload missed");
    a_lane_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_go && !wr_strobe_ok |=> $stable(sel0_base_ff) && $stable(gnr_base_ff))
        else $error("write without lane 0 changed a register");
    a_doze_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        doze_start_o |=> !doze_start_o) else $error("doze start longer than a cycle");

    c_gnr_hit: cover property (@(posedge ref_clk_i) general_range_activity_o);
    c_sel0: cover property (@(posedge ref_clk_i) !decode_o.sel0_n);
    c_sel1: cover property (@(posedge ref_clk_i) !decode_o.sel1_n);
    c_irq: cover property (@(posedge ref_clk_i) irq_o);
    c_lane_off: cover property (@(posedge ref_clk_i) wr_go && !wr_strobe_ok);
endmodule

//--- testbench/range_decode_peer.sv
`timescale 1ns/1ns
module range_decode_peer (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    input  wire range_decode_pkg::decode_out_t decode_i,
    output int                                 sel0_seen_o,
    output int                                 sel1_seen_o
);
    import range_decode_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // a peripheral claims one access per cycle its select is low; strobes
    // are counted, not latched, so a select stuck low shows up as extra counts
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel0_seen_o <= 0;
            sel1_seen_o <= 0;
        end else begin
            if (decode_i.sel0_n === 1'b0) sel0_seen_o <= sel0_seen_o + 1;
            if (decode_i.sel1_n === 1'b0) sel1_seen_o <= sel1_seen_o + 1;
        end
    end
endmodule

//--- testbench/range_decode_tb.sv
`timescale 1ns/1ns
`include "range_decode_defines.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module range_decode_tb;
    import range_decode_pkg::*;
    typedef struct packed {
        logic [1:0]  dec;
        logic [7:0]  base;
        logic [7:0]  ctrl;
        logic        mem;
        logic        wr;
        logic [22:0] addr;
        logic        hit;
    } row_t;
    logic        ref_clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata_o, d;
    logic [3:0]  wstrb, strb;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, resume, doze, susp;
    logic        act_o, idle_o, smi_o, doze_o, susp_o, irq_o, got;
    host_cycle_t hc;
    decode_out_t dec_o;
    int          errors, tests_run, doze_seen, susp_seen, s0_exp, s1_exp, s0_seen, s1_seen;
    row_t rows [16] = '{
        '{2'd0, 8'h40, 8'h40, 1'b0, 1'b1, 23'h000040, 1'b1}, '{2'd0, 8'h40, 8'h40, 1'b0, 1'b1, 23'h000041, 1'b0},
        '{2'd0, 8'h40, 8'h5F, 1'b0, 1'b1, 23'h00005F, 1'b1}, '{2'd0, 8'h40, 8'h5F, 1'b0, 1'b1, 23'h000060, 1'b0},
        '{2'd0, 8'h40, 8'h40, 1'b0, 1'b0, 23'h000040, 1'b0}, '{2'd0, 8'h40, 8'h3F, 1'b0, 1'b0, 23'h00005F, 1'b1},
        '{2'd0, 8'h40, 8'h20, 1'b0, 1'b1, 23'h000040, 1'b0}, '{2'd0, 8'h40, 8'hC0, 1'b0, 1'b1, 23'h000140, 1'b1},
        '{2'd0, 8'h40, 8'hC0, 1'b0, 1'b1, 23'h000040, 1'b0}, '{2'd0, 8'h12, 8'h40, 1'b1, 1'b1, 23'h04BFFF, 1'b1},
        '{2'd1, 8'h30, 8'h4F, 1'b0, 1'b1, 23'h00003F, 1'b1}, '{2'd1, 8'h30, 8'h4F, 1'b0, 1'b1, 23'h00002F, 1'b0},
        '{2'd1, 8'h30, 8'h5F, 1'b0, 1'b1, 23'h000020, 1'b0}, '{2'd2, 8'h80, 8'h4F, 1'b0, 1'b1, 23'h00008A, 1'b1},
        '{2'd2, 8'h80, 8'h4F, 1'b0, 1'b1, 23'h000090, 1'b0}, '{2'd2, 8'h80, 8'h48, 1'b1, 1'b1, 23'h220000, 1'b1}};

    range_decode dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata_o), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .host_cycle_i(hc), .resume_ready_i(resume),
        .doze_timeout_i(doze), .suspend_active_i(susp), .decode_o(dec_o),
        .general_range_activity_o(act_o), .idle_reload_o(idle_o), .smi_request_o(smi_o),
        .doze_start_o(doze_o), .suspend_start_o(susp_o), .irq_o(irq_o));
    range_decode_peer peer_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .decode_i(dec_o),
        .sel0_seen_o(s0_seen), .sel1_seen_o(s1_seen));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (doze_o === 1'b1) doze_seen++;
        if (susp_o === 1'b1) susp_seen++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [7:0] ba(input logic [7:0] idx);
        return 8'(idx << 2);
    endfunction
    // ready is sampled at the falling edge, where it is settled until the taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
        int  i;
        bit  done, aw_go, w_go;
        done = 0;
        awaddr <= a; wdata <= {24'h000000, v}; wstrb <= strb;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 40 && !done; i++) begin
            @(negedge ref_clk_i);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            if (bvalid === 1'b1) begin resp = bresp; done = 1; end
            @(posedge ref_clk_i);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) begin errors++; complete_run(); end
        #1;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] resp);
        int  i;
        bit  done, ar_go;
        done = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 40 && !done; i++) begin
            @(negedge ref_clk_i);
            ar_go = arvalid && arready;
            if (rvalid === 1'b1) begin q = rdata_o; resp = rresp; done = 1; end
            @(posedge ref_clk_i);
            if (ar_go) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) begin errors++; complete_run(); end
        #1;
    endtask
    task automatic host(input logic mem, input logic wr, input logic [22:0] a);
        hc <= '{1'b1, mem, wr, a};
        @(posedge ref_clk_i);
        hc.valid <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; hc = '0;
        resume = 0; doze = 0; susp = 0; errors = 0; tests_run = 0; doze_seen = 0;
        susp_seen = 0; s0_exp = 0; s1_exp = 0; strb = 4'h1;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        `CHK("decode idle", 3'b110, dec_o)
        for (int i = 8'h48; i <= 8'h50; i++) begin
            axi_rd(ba(8'(i)), d, r);
            `CHK("reset value", 32'h00000000, d)
        end
        axi_rd(8'h60, d, r);
        `CHK("status reset", 32'h00000000, d)
        for (int i = 8'h48; i <= 8'h4F; i++) begin
            axi_wr(ba(8'(i)), 8'hA5, r);
            `CHK("wr resp", 2'h0, r)
            axi_rd(ba(8'(i)), d, r);
            `CHK("rw reg", 32'h000000A5, d)
            `CHK("rd resp", 2'h0, r)
            axi_wr(ba(8'(i)), 8'h00, r);
        end
        axi_wr(ba(`OFS_IDLE_EN), 8'hC8, r);
        // ordinary decode cases
        foreach (rows[k]) begin
            axi_wr(ba(8'(`OFS_GNR_BASE + 2 * rows[k].dec)), rows[k].base, r);
            axi_wr(ba(8'(`OFS_GNR_CTRL + 2 * rows[k].dec)), rows[k].ctrl, r);
            host(rows[k].mem, rows[k].wr, rows[k].addr);
            got = (rows[k].dec == 0) ? dec_o.gnr_hit : (rows[k].dec == 1) ? !dec_o.sel0_n : !dec_o.sel1_n;
            `CHK("decode hit", rows[k].hit, got)
            `CHK("activity", rows[k].hit && rows[k].dec == 0, act_o)
            `CHK("idle reload", rows[k].hit, idle_o)
            if (rows[k].dec == 1) s0_exp += rows[k].hit;
            if (rows[k].dec == 2) s1_exp += rows[k].hit;
        end
        @(posedge ref_clk_i);
        #1;
        `CHK("peer sel0", s0_exp, s0_seen)
        `CHK("peer sel1", s1_exp, s1_seen)
        // interrupts: every decoder hit at least once above
        `CHK("irq masked", 1'b0, irq_o)
        axi_rd(8'h60, d, r);
        `CHK("status", 32'h00000007, d)
        axi_wr(8'h64, 8'h02, r);
        `CHK("irq on", 1'b1, irq_o)
        axi_wr(8'h60, 8'h02, r);
        `CHK("irq cleared", 1'b0, irq_o)
        axi_rd(8'h60, d, r);
        `CHK("status clr", 32'h00000005, d)
        axi_wr(8'h64, 8'h07, r);
        `CHK("irq remask", 1'b1, irq_o)
        axi_wr(8'h60, 8'h07, r);
        `CHK("irq all clr", 1'b0, irq_o)
        // unmapped place
        axi_wr(8'h7C, 8'h11, r);
        `CHK("unmapped wr", 2'h2, r)
        axi_rd(8'h7C, d, r);
        `CHK("unmapped rd", 2'h2, r)
        // a write with byte lane 0 off is answered but leaves the register alone
        strb = 4'h0;
        axi_wr(ba(`OFS_SEL0_BASE), 8'h5A, r);
        strb = 4'h1;
        `CHK("lane off resp", 2'h0, r)
        axi_rd(ba(`OFS_SEL0_BASE), d, r);
        `CHK("lane off", 32'h00000030, d)
        // control five: status bits follow inputs, writes to them are ignored
        resume <= 1'b1; susp <= 1'b1; doze <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        axi_wr(ba(`OFS_PWR_CTRL5), 8'h8D, r);
        axi_rd(ba(`OFS_PWR_CTRL5), d, r);
        `CHK("ctrl5 set", 32'h0000008E, d)
        `CHK("smi on", 1'b1, smi_o)
        `CHK("doze pulse", 1, doze_seen)
        `CHK("susp pulse", 1, susp_seen)
        resume <= 1'b0; susp <= 1'b0; doze <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        axi_wr(ba(`OFS_PWR_CTRL5), 8'h04, r);
        axi_rd(ba(`OFS_PWR_CTRL5), d, r);
        `CHK("ctrl5 clr", 32'h00000000, d)
        `CHK("smi off", 1'b0, smi_o)
        // reset in mid-run drops programmed ranges
        axi_wr(ba(`OFS_GNR_CTRL), 8'h40, r);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        `CHK("decode in reset", 3'b110, dec_o)
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        axi_rd(ba(`OFS_GNR_CTRL), d, r);
        `CHK("ctrl after reset", 32'h00000000, d)
        host(1'b0, 1'b1, 23'h000012);
        `CHK("decode after reset", 1'b0, act_o)
        complete_run();
    end
endmodule
